/* inc/tlao_regs.vh */
`ifndef TLAO_REGS_VH
`define TLAO_REGS_VH

// register indices on the plain register port
`define TLAO_ADDR_W 4
`define TLAO_A_LOC_TEMP 4'h0
`define TLAO_A_REM_TEMP 4'h1
`define TLAO_A_STATUS 4'h2
`define TLAO_A_CONFIG 4'h3
`define TLAO_A_LOC_HIGH 4'h4
`define TLAO_A_LOC_LOW 4'h5
`define TLAO_A_REM_HIGH 4'h6
`define TLAO_A_REM_LOW 4'h7
`define TLAO_A_LOC_CRIT 4'h8
`define TLAO_A_REM_CRIT 4'h9
`define TLAO_A_HYST 4'ha
`define TLAO_A_OFFSET 4'hb
`define TLAO_A_IRQ_MASK 4'hc

// status bit positions
`define TLAO_ST_LOC_HIGH 6
`define TLAO_ST_LOC_LOW 5
`define TLAO_ST_REM_HIGH 4
`define TLAO_ST_REM_LOW 3
`define TLAO_ST_OPEN 2
`define TLAO_ST_REM_CRIT 1
`define TLAO_ST_LOC_CRIT 0
`define TLAO_ST_ALARM_MASK 8'h7c

// config bit positions
`define TLAO_CFG_ALARM_MASK 7
`define TLAO_CFG_PIN_SEC 5

// reset values
`define TLAO_RST_HIGH 8'h55
`define TLAO_RST_LOW 8'h00
`define TLAO_RST_CRIT 8'h55
`define TLAO_RST_HYST 8'h0a
`define TLAO_RST_CONFIG 8'h00

// channel numbering
`define TLAO_CH_LOC 1'b0
`define TLAO_CH_REM 1'b1

`endif

/* rtl/tlao_offs_add.v */
`timescale 1ns/1ps
// signed add of the offset with clamping to the 8-bit range
module tlao_offs_add #(
   parameter W = 8
) (
   input wire [W-1:0] raw,
   input wire [W-1:0] offs,
   input wire en,
   output reg [W-1:0] sum
);
   reg [W:0] ext;

   // one extra bit exposes overflow, then clamp
   always @* begin
      ext = {raw[W-1], raw} + ({W+1{en}} & {offs[W-1], offs});
      if (ext[W] != ext[W-1]) begin
         sum = ext[W] ? {1'b1, {W-1{1'b0}}} : {1'b0, {W-1{1'b1}}};
      end else begin
         sum = ext[W-1:0];
      end
   end
endmodule // tlao_offs_add

/* rtl/tlao_chan.v */
`timescale 1ns/1ps
// limit compares for one channel plus the two hysteresis latches
module tlao_chan #(
   parameter W = 8
) (
   input wire ref_clk,
   input wire rst,
   input wire [W-1:0] temp,
   input wire [W-1:0] high_lim,
   input wire [W-1:0] low_lim,
   input wire [W-1:0] crit_lim,
   input wire [W-1:0] hyst,
   output wire high_hit,
   output wire low_hit,
   output reg crit_ff,
   output reg sec_ff
);
   // sign-extend by two bits so limit minus hysteresis cannot wrap
   wire signed [W+1:0] t_s = {{2{temp[W-1]}}, temp};
   wire signed [W+1:0] hi_s = {{2{high_lim[W-1]}}, high_lim};
   wire signed [W+1:0] lo_s = {{2{low_lim[W-1]}}, low_lim};
   wire signed [W+1:0] cr_s = {{2{crit_lim[W-1]}}, crit_lim};
   wire signed [W+1:0] hy_s = {2'b00, hyst};
   reg nxt_crit;
   reg nxt_sec;

   assign high_hit = t_s > hi_s;
   assign low_hit = t_s <= lo_s;

   // assert above limit, release at limit minus hysteresis, else hold
   always @* begin
      nxt_crit = crit_ff;
      nxt_sec = sec_ff;
      if (t_s > cr_s) begin
         nxt_crit = 1'b1;
      end else if (t_s <= cr_s - hy_s) begin
         nxt_crit = 1'b0;
      end
      if (t_s > hi_s) begin
         nxt_sec = 1'b1;
      end else if (t_s <= hi_s - hy_s) begin
         nxt_sec = 1'b0;
      end
   end

   // latch state
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         crit_ff <= 1'b0;
         sec_ff <= 1'b0;
      end else begin
         crit_ff <= nxt_crit;
         sec_ff <= nxt_sec;
      end
   end
endmodule // tlao_chan

/* rtl/tlao_top.v */
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "tlao_regs.vh"
module tlao_top #(
   parameter W = 8
) (
   input wire ref_clk,
   input wire rst,
   input wire [`TLAO_ADDR_W-1:0] reg_addr,
   input wire [W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [W-1:0] reg_rdata_ff,
   input wire conv_start,
   input wire open_fault,
   input wire conv_done,
   input wire conv_chan,
   input wire [W-1:0] conv_raw,
   input wire ara_done,
   output reg alert_n_ff,
   output reg critical_out_n_ff,
   output reg irq_ff
);
   // stored results and limits, index 0 local, 1 remote
   reg [W-1:0] temp_ff [0:1];
   reg [W-1:0] high_ff [0:1];
   reg [W-1:0] low_ff [0:1];
   reg [W-1:0] crit_lim_ff [0:1];
   reg [W-1:0] hyst_ff;
   reg [W-1:0] offset_ff;
   reg [W-1:0] config_ff;
   reg [W-1:0] status_ff;
   reg [W-1:0] mask_ff;
   reg open_now_ff;
   reg alarm_ff;
   reg ara_seen_ff;
   reg [W-1:0] nxt_status;
   reg [W-1:0] nxt_rdata;
   reg nxt_alarm;
   reg nxt_ara_seen;
   wire [W-1:0] conv_result;
   wire [1:0] high_hit;
   wire [1:0] low_hit;
   wire [1:0] crit_hit;
   wire [1:0] sec_hit;
   wire alarm_cond;
   wire [W-1:0] event_bits;
   wire wr_status;
   genvar ch;

   // remote results carry the signed offset
   // offset correction
   tlao_offs_add #(
      .W(W)
   ) u_offs (
      .raw(conv_raw),
      .offs(offset_ff),
      .en(conv_chan == `TLAO_CH_REM),
      .sum(conv_result)
   );

   // one compare block per channel, continuously on stored values
   // per-channel critical sources
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         tlao_chan #(
            .W(W)
         ) u_chan (
            .ref_clk(ref_clk),
            .rst(rst),
            .temp(temp_ff[ch]),
            .high_lim(high_ff[ch]),
            .low_lim(low_ff[ch]),
            .crit_lim(crit_lim_ff[ch]),
            .hyst(hyst_ff),
            .high_hit(high_hit[ch]),
            .low_hit(low_hit[ch]),
            .crit_ff(crit_hit[ch]),
            .sec_ff(sec_hit[ch])
         );
      end
   endgenerate

   // low limit and open sensor also raise the alarm
   assign alarm_cond = |high_hit | |low_hit | open_now_ff;

   // conditions that feed the sticky status bits
   assign event_bits = {1'b0, high_hit[0], low_hit[0], high_hit[1],
      low_hit[1], open_now_ff, crit_hit[1], crit_hit[0]};

   assign wr_status = reg_wr && (reg_addr == `TLAO_A_STATUS);

   // new results land in the result registers on completion
   // new result triggers compare
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         temp_ff[0] <= 8'h00;
         temp_ff[1] <= 8'h00;
      end else if (conv_done) begin
         temp_ff[conv_chan] <= conv_result;
      end
   end

   // open sensor sampled when a conversion begins
   // open flag capture
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         open_now_ff <= 1'b0;
      end else if (conv_start) begin
         open_now_ff <= open_fault;
      end
   end

   // writable registers
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         high_ff[0] <= `TLAO_RST_HIGH;
         high_ff[1] <= `TLAO_RST_HIGH;
         low_ff[0] <= `TLAO_RST_LOW;
         low_ff[1] <= `TLAO_RST_LOW;
         crit_lim_ff[0] <= `TLAO_RST_CRIT;
         crit_lim_ff[1] <= `TLAO_RST_CRIT;
         hyst_ff <= `TLAO_RST_HYST;
         offset_ff <= 8'h00;
         config_ff <= `TLAO_RST_CONFIG;
         mask_ff <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `TLAO_A_LOC_HIGH: high_ff[0] <= reg_wdata;
            `TLAO_A_LOC_LOW: low_ff[0] <= reg_wdata;
            `TLAO_A_REM_HIGH: high_ff[1] <= reg_wdata;
            `TLAO_A_REM_LOW: low_ff[1] <= reg_wdata;
            `TLAO_A_LOC_CRIT: crit_lim_ff[0] <= reg_wdata;
            `TLAO_A_REM_CRIT: crit_lim_ff[1] <= reg_wdata;
            `TLAO_A_HYST: hyst_ff <= reg_wdata;
            `TLAO_A_OFFSET: offset_ff <= reg_wdata;
            `TLAO_A_CONFIG: config_ff <= reg_wdata;
            `TLAO_A_IRQ_MASK: mask_ff <= reg_wdata;
            default: ;
         endcase
      end
   end

   // sticky status, write one clears, a live condition wins
   always @* begin
      nxt_status = status_ff;
      if (wr_status) begin
         nxt_status = nxt_status & ~reg_wdata;
      end
      nxt_status = nxt_status | event_bits;
   end

   // alarm latch with alert response servicing
   always @* begin
      nxt_alarm = alarm_ff;
      nxt_ara_seen = ara_seen_ff;
      if (ara_done && alarm_ff) begin
         nxt_ara_seen = 1'b1;
      end
      if (ara_seen_ff && ~alarm_cond &&
            ((status_ff & `TLAO_ST_ALARM_MASK) == 8'h00)) begin
         nxt_alarm = 1'b0;
         nxt_ara_seen = 1'b0;
      end
      if (alarm_cond && ~config_ff[`TLAO_CFG_ALARM_MASK]) begin
         nxt_alarm = 1'b1;
      end
   end

   // status and alarm state
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_ff <= 8'h00;
         alarm_ff <= 1'b0;
         ara_seen_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         alarm_ff <= nxt_alarm;
         ara_seen_ff <= nxt_ara_seen;
      end
   end

   // read mux, data one cycle after the strobe
   always @* begin
      case (reg_addr)
         `TLAO_A_LOC_TEMP: nxt_rdata = temp_ff[0];
         `TLAO_A_REM_TEMP: nxt_rdata = temp_ff[1];
         `TLAO_A_STATUS: nxt_rdata = status_ff;
         `TLAO_A_CONFIG: nxt_rdata = config_ff;
         `TLAO_A_LOC_HIGH: nxt_rdata = high_ff[0];
         `TLAO_A_LOC_LOW: nxt_rdata = low_ff[0];
         `TLAO_A_REM_HIGH: nxt_rdata = high_ff[1];
         `TLAO_A_REM_LOW: nxt_rdata = low_ff[1];
         `TLAO_A_LOC_CRIT: nxt_rdata = crit_lim_ff[0];
         `TLAO_A_REM_CRIT: nxt_rdata = crit_lim_ff[1];
         `TLAO_A_HYST: nxt_rdata = hyst_ff;
         `TLAO_A_OFFSET: nxt_rdata = offset_ff;
         `TLAO_A_IRQ_MASK: nxt_rdata = mask_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end

   // pin drivers, all registered; alert and critical active low, irq active high
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alert_n_ff <= 1'b1;
         critical_out_n_ff <= 1'b1;
         irq_ff <= 1'b0;
      end else begin
         critical_out_n_ff <= ~(|crit_hit);
         if (config_ff[`TLAO_CFG_PIN_SEC]) begin
            alert_n_ff <= ~(|sec_hit);
         end else begin
            alert_n_ff <= ~alarm_ff;
         end
         irq_ff <= |(status_ff & mask_ff);
      end
   end
endmodule // tlao_top

/* verif/tlao_top_sva.sv */
`timescale 1ns/1ps
module tlao_chk #(
   parameter W = 8
) (
   input wire ref_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [W-1:0] reg_rdata_ff,
   input wire conv_start,
   input wire open_fault,
   input wire conv_done,
   input wire conv_chan,
   input wire [W-1:0] conv_raw,
   input wire ara_done,
   input wire alert_n_ff,
   input wire critical_out_n_ff,
   input wire irq_ff
);
   reg [W-1:0] cfg_ff;
   reg [W-1:0] hys_ff;
   reg [W-1:0] msk_ff;
   reg [4:0] ev_ff;
   reg ara_ff;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // shadow of written registers and of recent causes of change
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= 8'h00;
         hys_ff <= 8'h0a;
         msk_ff <= 8'h00;
         ev_ff <= 5'h00;
         ara_ff <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 4'h3) cfg_ff <= reg_wdata;
         if (reg_wr && reg_addr == 4'ha) hys_ff <= reg_wdata;
         if (reg_wr && reg_addr == 4'hc) msk_ff <= reg_wdata;
         ev_ff <= {ev_ff[3:0], conv_done | reg_wr | ara_done};
         ara_ff <= alert_n_ff ? 1'b0 : (ara_ff | ara_done);
      end
   end
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
      else $error("read data not zero outside a read");
   cfg_read_a: assert property (reg_rd && reg_addr == 4'h3 |=>
      reg_rdata_ff == cfg_ff) else $error("config read mismatch");
   hyst_read_a: assert property (reg_rd && reg_addr == 4'ha |=>
      reg_rdata_ff == hys_ff) else $error("hysteresis read mismatch");
   unmapped_read_a: assert property (reg_rd && reg_addr > 4'hc |=>
      reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
   crit_cause_a: assert property ($changed(critical_out_n_ff) |->
      |ev_ff) else $error("critical moved with no cause");
   alert_cause_a: assert property ($rose(alert_n_ff) |-> |ev_ff)
      else $error("alert released with no cause");
   alert_ara_a: assert property ($rose(alert_n_ff) && !cfg_ff[5] |->
      ara_ff) else $error("alert released without response read");
   irq_masked_a: assert property (msk_ff == 8'h00 &&
      $past(msk_ff) == 8'h00 |-> !irq_ff) else $error("irq while masked");
endmodule // tlao_chk

bind tlao_top tlao_chk #(.W(W)) u_chk (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .conv_start(conv_start),
   .open_fault(open_fault), .conv_done(conv_done), .conv_chan(conv_chan),
   .conv_raw(conv_raw), .ara_done(ara_done), .alert_n_ff(alert_n_ff),
   .critical_out_n_ff(critical_out_n_ff), .irq_ff(irq_ff));

/* verif/tlao_host_model.sv */
`timescale 1ns/1ps
module tlao_host_model (
   input wire ref_clk,
   input wire rst,
   input wire alert_n,
   output wire ara_done
);
   reg [2:0] low_cnt_ff;
   // count cycles of a low alert line, saturating
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         low_cnt_ff <= 3'h0;
      end else if (alert_n) begin
         low_cnt_ff <= 3'h0;
      end else if (low_cnt_ff != 3'h7) begin
         low_cnt_ff <= low_cnt_ff + 3'h1;
      end
   end
   assign ara_done = (low_cnt_ff == 3'h4);
endmodule // tlao_host_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
   reg ref_clk, rst, reg_wr, reg_rd, conv_start, open_fault, conv_done;
   reg conv_chan;
   reg [3:0] reg_addr;
   reg [7:0] reg_wdata, conv_raw;
   wire [7:0] reg_rdata_ff;
   wire ara_done, alert_n_ff, critical_out_n_ff, irq_ff;
   integer error_cnt, num_checks;
   tlao_top #(.W(8)) i_dut (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .conv_start(conv_start),
      .open_fault(open_fault), .conv_done(conv_done), .conv_chan(conv_chan),
      .conv_raw(conv_raw), .ara_done(ara_done), .alert_n_ff(alert_n_ff),
      .critical_out_n_ff(critical_out_n_ff), .irq_ff(irq_ff));
   tlao_host_model i_host (.ref_clk(ref_clk), .rst(rst),
      .alert_n(alert_n_ff), .ara_done(ara_done));
   // clock source
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge ref_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] a, input [7:0] exp);
      begin
         @(posedge ref_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1;
         chk(reg_rdata_ff, exp);
      end
   endtask
   // one result on a channel, then wait for the pins to follow
   task conv(input ch, input [7:0] raw);
      begin
         @(posedge ref_clk);
         conv_done <= 1'b1;
         conv_chan <= ch;
         conv_raw <= raw;
         @(posedge ref_clk);
         conv_done <= 1'b0;
         repeat (3) @(posedge ref_clk);
         #1;
      end
   endtask
   task wait_hi;
      integer i;
      begin
         for (i = 0; i < 60 && alert_n_ff !== 1'b1; i = i + 1) begin
            @(posedge ref_clk);
            #1;
         end
         chk({7'h00, alert_n_ff}, 8'h01);
      end
   endtask
   task t_reset;
      begin
         rd(4'ha, 8'h0a);
         chk({7'h00, alert_n_ff}, 8'h00);
         rd(4'h3, 8'h00);
         rd(4'he, 8'h00);
         wr(4'h0, 8'h33);
         rd(4'h0, 8'h00);
         wr(4'h5, 8'h80);
         wr(4'h7, 8'h80);
         wr(4'h2, 8'h7f);
         wait_hi;
         $display("t_reset done");
      end
   endtask
   task t_crit;
      begin
         wr(4'hb, 8'h05);
         conv(1'b1, 8'h51);
         chk({7'h00, critical_out_n_ff}, 8'h00);
         rd(4'h1, 8'h56);
         conv(1'b1, 8'h4c);
         chk({7'h00, critical_out_n_ff}, 8'h00);
         conv(1'b1, 8'h46);
         chk({7'h00, critical_out_n_ff}, 8'h01);
         conv(1'b0, 8'h55);
         chk({7'h00, critical_out_n_ff}, 8'h01);
         conv(1'b0, 8'h60);
         chk({7'h00, critical_out_n_ff}, 8'h00);
         conv(1'b0, 8'h00);
         chk({7'h00, critical_out_n_ff}, 8'h01);
         wr(4'h2, 8'h7f);
         wait_hi;
         $display("t_crit done");
      end
   endtask
   task t_alarm;
      begin
         wr(4'h4, 8'h40);
         conv(1'b0, 8'h41);
         chk({7'h00, alert_n_ff}, 8'h00);
         rd(4'h2, 8'h40);
         wr(4'hc, 8'h40);
         @(posedge ref_clk);
         #1;
         chk({7'h00, irq_ff}, 8'h01);
         conv(1'b0, 8'h10);
         repeat (8) @(posedge ref_clk);
         #1;
         chk({7'h00, alert_n_ff}, 8'h00);
         wr(4'h2, 8'h40);
         wait_hi;
         chk({7'h00, irq_ff}, 8'h00);
         wr(4'hc, 8'h00);
         @(posedge ref_clk);
         conv_start <= 1'b1;
         open_fault <= 1'b1;
         @(posedge ref_clk);
         conv_start <= 1'b0;
         open_fault <= 1'b0;
         repeat (3) @(posedge ref_clk);
         rd(4'h2, 8'h04);
         chk({7'h00, alert_n_ff}, 8'h00);
         // a new conversion start with a good sensor removes the open cause
         @(posedge ref_clk);
         conv_start <= 1'b1;
         @(posedge ref_clk);
         conv_start <= 1'b0;
         @(posedge ref_clk);
         #1;
         chk({7'h00, alert_n_ff}, 8'h00);
         wr(4'h2, 8'h04);
         wait_hi;
         $display("t_alarm done");
      end
   endtask
   task t_sec;
      begin
         wr(4'h3, 8'h20);
         conv(1'b1, 8'h51);
         chk({7'h00, alert_n_ff}, 8'h00);
         wr(4'h3, 8'ha0);
         repeat (3) @(posedge ref_clk);
         #1;
         chk({7'h00, alert_n_ff}, 8'h00);
         conv(1'b1, 8'h4c);
         chk({7'h00, alert_n_ff}, 8'h00);
         conv(1'b1, 8'h46);
         chk({7'h00, alert_n_ff}, 8'h01);
         wr(4'h3, 8'h00);
         $display("t_sec done");
      end
   endtask
   task test_done;
      begin
         $display("checks %0d errors %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt = error_cnt + 1;
      test_done;
   end
   // main sequence
   initial begin
      error_cnt = 0;
      num_checks = 0;
      rst = 1'b1;
      {reg_wr, reg_rd, conv_start, open_fault, conv_done, conv_chan} = 6'h00;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      conv_raw = 8'h00;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_crit;
      t_alarm;
      t_sec;
      test_done;
   end
endmodule // testbench
